// ==== pkg/osc_pkg.sv ====
// Package for the oscillator mode and PLL ratio selection block.
// Assumes a 32-bit Avalon-MM slave port with byte addresses and aligned words.
package osc_pkg;

   // Register byte offsets.
   localparam logic [3:0] CLK_CTRL_OFFSET   = 4'h0;
   localparam logic [3:0] OSC_STATUS_OFFSET = 4'h4;

   // Clock control register: PLL ratio field, most significant bit in bit 6.
   localparam int         RATIO_LSB         = 4;
   localparam int         RATIO_MSB         = 6;
   localparam logic [2:0] RATIO_RESET       = 3'h0;

   // Oscillator status register fields.
   localparam int         STAT_MAIN_LSB     = 0;
   localparam int         STAT_SUB_BIT      = 2;
   localparam int         STAT_PLL_BIT      = 3;
   localparam int         STAT_VALID_BIT    = 4;
   localparam int         STAT_MULT_LSB     = 16;

   // Multiplier in quarter units, so that 65/4 stays exact.
   localparam logic [9:0] MULT_Q4_130       = 10'h208;
   localparam logic [9:0] MULT_Q4_65        = 10'h104;
   localparam logic [9:0] MULT_Q4_65_2      = 10'h082;
   localparam logic [9:0] MULT_Q4_65_4      = 10'h041;
   localparam logic [9:0] MULT_Q4_244       = 10'h3d0;

   // Main oscillator kinds.
   typedef enum logic [1:0] {MAIN_RC, MAIN_XTAL, MAIN_PLL} main_osc_t;

   // Latched oscillator configuration.
   typedef struct packed {
      main_osc_t main_type;
      logic      sub_crystal;
   } osc_cfg_t;

   // Decodes the two main-mode option bits.
   function automatic main_osc_t main_decode(input logic [1:0] sel);
      main_osc_t m;
      m = MAIN_RC;
      case (sel)
         2'h0:    m = MAIN_RC;
         2'h1:    m = MAIN_XTAL;
         default: m = MAIN_PLL;
      endcase
      return m;
   endfunction : main_decode

   // Maps the ratio field to the multiplier in quarter units.
   function automatic logic [9:0] pll_mult_q4(input logic [2:0] sel);
      logic [9:0] m;
      m = MULT_Q4_244;
      case (sel)
         3'h0:    m = MULT_Q4_130;
         3'h1:    m = MULT_Q4_65;
         3'h2:    m = MULT_Q4_65_2;
         3'h3:    m = MULT_Q4_65_4;
         default: m = MULT_Q4_244;
      endcase
      return m;
   endfunction : pll_mult_q4

endpackage : osc_pkg

// ==== hdl/osc_mode_and_pll_select.sv ====
// Oscillator mode selection and PLL ratio register for a small controller.
// Assumes static option pins from outside the clock domain and an Avalon-MM master.
// Assumes i_reset is synchronous to i_clk_sys and held for at least two edges.
// The option pins must settle before reset release; later changes are ignored.
//
// Local design decisions: the register offsets and the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none

module osc_mode_and_pll_select (
   // Clock and reset.
   input  wire logic              i_clk_sys,
   input  wire logic              i_reset,
   // Option word pins.
   input  wire logic              i_main_osc_type_sel_hi,
   input  wire logic              i_main_osc_type_sel_lo,
   input  wire logic              i_sub_osc_type_sel,
   // Avalon-MM slave.
   input  wire logic [3:0]        i_avs_address,
   input  wire logic              i_avs_read,
   input  wire logic              i_avs_write,
   input  wire logic [31:0]       i_avs_writedata,
   input  wire logic [3:0]        i_avs_byteenable,
   output logic [31:0]            o_avs_readdata,
   output logic                   o_avs_waitrequest,
   // Clock selection results.
   output osc_pkg::osc_cfg_t      o_osc_cfg,
   output logic                   o_cfg_valid,
   output logic                   o_pll_enable,
   output logic                   o_main_from_sub,
   output logic [2:0]             o_pll_ratio_sel,
   output logic [9:0]             o_pll_mult_q4
);

   logic [2:0] opt_meta_q;
   logic [2:0] opt_sync_q;
   logic       req;
   logic       wr_acc;
   logic       rd_sel_ctrl;
   logic       chk_run_q;

   // PLL routing decision, shared by both routing outputs so they cannot drift apart.
   // It reads the captured copy only, so a pin that moves later cannot reroute the clock.
   function automatic logic pll_selected(input osc_pkg::osc_cfg_t cfg, input logic valid);
      return valid && (cfg.main_type == osc_pkg::MAIN_PLL);
   endfunction : pll_selected

   // Option pins cross into the clock domain; left unreset so they fill during reset.
   always_ff @(posedge i_clk_sys) begin
      opt_meta_q <= {i_sub_osc_type_sel, i_main_osc_type_sel_hi, i_main_osc_type_sel_lo};
      opt_sync_q <= opt_meta_q;
   end

   // Capture once, on the first edge after reset release; nothing else writes it.
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         o_osc_cfg   <= '{main_type: osc_pkg::MAIN_RC, sub_crystal: 1'b0};
         o_cfg_valid <= 1'b0;
      end else if (!o_cfg_valid) begin
         o_osc_cfg.main_type   <= osc_pkg::main_decode(opt_sync_q[1:0]);
         o_osc_cfg.sub_crystal <= opt_sync_q[2];
         o_cfg_valid           <= 1'b1;
      end
   end

   // PLL mode routes the sub-oscillator into the multiplier as main clock source.
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         o_pll_enable    <= 1'b0;
         o_main_from_sub <= 1'b0;
      end else begin
         o_pll_enable    <= pll_selected(o_osc_cfg, o_cfg_valid);
         o_main_from_sub <= pll_selected(o_osc_cfg, o_cfg_valid);
      end
   end

   // Bus handshake: one wait cycle, then the request completes.
   assign req    = i_avs_read || i_avs_write;
   assign wr_acc = i_avs_write && !o_avs_waitrequest;
   assign rd_sel_ctrl = (i_avs_address == osc_pkg::CLK_CTRL_OFFSET);

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         o_avs_waitrequest <= 1'b1;
      end else if (req && o_avs_waitrequest) begin
         o_avs_waitrequest <= 1'b0;
      end else begin
         o_avs_waitrequest <= 1'b1;
      end
   end

   // Only the ratio field is writable; oscillator types have no write path at all.
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         o_pll_ratio_sel <= osc_pkg::RATIO_RESET;
      end else if (wr_acc && rd_sel_ctrl && i_avs_byteenable[0]) begin
         o_pll_ratio_sel <= i_avs_writedata[osc_pkg::RATIO_MSB:osc_pkg::RATIO_LSB];
      end
   end

   // Multiplier follows the ratio field one cycle later.
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         o_pll_mult_q4 <= osc_pkg::pll_mult_q4(osc_pkg::RATIO_RESET);
      end else begin
         o_pll_mult_q4 <= osc_pkg::pll_mult_q4(o_pll_ratio_sel);
      end
   end

   // Read data is built in the wait cycle and held for the completing edge.
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         o_avs_readdata <= 32'h0;
      end else if (i_avs_read && o_avs_waitrequest) begin
         o_avs_readdata <= 32'h0;
         if (rd_sel_ctrl) begin
            o_avs_readdata[osc_pkg::RATIO_MSB:osc_pkg::RATIO_LSB] <= o_pll_ratio_sel;
         end else if (i_avs_address == osc_pkg::OSC_STATUS_OFFSET) begin
            o_avs_readdata[osc_pkg::STAT_MAIN_LSB +: 2]  <= o_osc_cfg.main_type;
            o_avs_readdata[osc_pkg::STAT_SUB_BIT]        <= o_osc_cfg.sub_crystal;
            o_avs_readdata[osc_pkg::STAT_PLL_BIT]        <= o_pll_enable;
            o_avs_readdata[osc_pkg::STAT_VALID_BIT]      <= o_cfg_valid;
            o_avs_readdata[osc_pkg::STAT_MULT_LSB +: 10] <= o_pll_mult_q4;
         end
      end
   end

   // Checks.
   sequence ctrl_write_s;
      wr_acc && rd_sel_ctrl && i_avs_byteenable[0];
   endsequence

   sequence capture_s;
      $rose(o_cfg_valid);
   endsequence

   main_decode_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      capture_s |-> o_osc_cfg.main_type == osc_pkg::main_decode($past(opt_sync_q[1:0])))
      else $error("Main oscillator type does not match option bits.");

   sub_decode_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      capture_s |-> o_osc_cfg.sub_crystal == $past(opt_sync_q[2]))
      else $error("Sub oscillator type does not match option bit.");

   pll_source_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      o_cfg_valid && o_osc_cfg.main_type == osc_pkg::MAIN_PLL |=> o_pll_enable && o_main_from_sub)
      else $error("PLL mode did not route the sub clock.");

   mult_value_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      ctrl_write_s |-> ##2
         o_pll_mult_q4 == osc_pkg::pll_mult_q4($past(i_avs_writedata[osc_pkg::RATIO_MSB:osc_pkg::RATIO_LSB], 2)))
      else $error("PLL multiplier wrong after ratio write.");

   ratio_field_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      i_avs_read && !o_avs_waitrequest && rd_sel_ctrl |->
         o_avs_readdata == {25'h0, o_pll_ratio_sel, 4'h0})
      else $error("Ratio field not read back in bits 6 to 4.");

   option_static_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      o_cfg_valid ##1 o_cfg_valid |-> $stable(o_osc_cfg))
      else $error("Oscillator configuration changed after capture.");

   // Further checks on the bus handshake, the refused writes, the read data, the PLL routing, the multiplier and the capture.
   // They watch only what this block drives; the master's side is kept by its owner.

   // Check helper: low in reset, high from the first edge after release onward.
   // It names the capture edge for the checks below without leaning on $rose.
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         chk_run_q <= 1'b0;
      end else begin
         chk_run_q <= 1'b1;
      end
   end

   // A request that the slave has not answered yet.
   sequence req_wait_s;
      (i_avs_read || i_avs_write) && o_avs_waitrequest;
   endsequence

   // Completing edge of a status read.
   sequence status_read_done_s;
      i_avs_read && !o_avs_waitrequest && (i_avs_address == osc_pkg::OSC_STATUS_OFFSET);
   endsequence

   // Completing edge of a read from an address that maps to nothing.
   sequence other_read_done_s;
      i_avs_read && !o_avs_waitrequest && !rd_sel_ctrl && (i_avs_address != osc_pkg::OSC_STATUS_OFFSET);
   endsequence

   // A completed write that must leave the ratio field alone.
   sequence dropped_write_s;
      wr_acc && !(rd_sel_ctrl && i_avs_byteenable[0]);
   endsequence

   // A captured main type other than PLL.
   sequence non_pll_cfg_s;
      o_cfg_valid && (o_osc_cfg.main_type != osc_pkg::MAIN_PLL);
   endsequence

   // The slave inserts exactly one wait cycle.
   // A master must still wait for it rather than count on it.
   wait_answer_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      req_wait_s |=> !o_avs_waitrequest)
      else $error("Request was not answered after one wait cycle.");

   // Waitrequest low stands for one cycle only, so a held strobe is not taken twice.
   wait_release_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      !o_avs_waitrequest |=> o_avs_waitrequest)
      else $error("Waitrequest stayed low for more than one cycle.");

   // With no strobe up, no completion may appear.
   idle_wait_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      !(i_avs_read || i_avs_write) |=> o_avs_waitrequest)
      else $error("Waitrequest dropped without a request.");

   // Refused writes: wrong address, or byte lane 0 disabled.
   // Software may rely on this to touch other bytes without moving the ratio.
   write_drop_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      dropped_write_s |=> $stable(o_pll_ratio_sel))
      else $error("Ratio field changed on a refused write.");

   // Without a completed write the ratio field holds its value.
   // A glitch here would retune the PLL with no software action at all.
   ratio_idle_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      !wr_acc |=> $stable(o_pll_ratio_sel))
      else $error("Ratio field changed without a write.");

   // Status word: the capture as sampled in the wait cycle.
   // Read data is built one edge before completion, so $past lines the two up.
   status_layout_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      status_read_done_s |->
         o_avs_readdata[osc_pkg::STAT_MAIN_LSB +: 2] == $past(o_osc_cfg.main_type)
         && o_avs_readdata[osc_pkg::STAT_SUB_BIT] == $past(o_osc_cfg.sub_crystal)
         && o_avs_readdata[osc_pkg::STAT_PLL_BIT] == $past(o_pll_enable)
         && o_avs_readdata[osc_pkg::STAT_VALID_BIT] == $past(o_cfg_valid)
         && o_avs_readdata[osc_pkg::STAT_MULT_LSB +: 10] == $past(o_pll_mult_q4))
      else $error("Status word does not match the captured configuration.");

   // Spare status bits read as zero.
   status_spare_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      status_read_done_s |-> o_avs_readdata[31:osc_pkg::STAT_MULT_LSB + 10] == 6'h0
         && o_avs_readdata[osc_pkg::STAT_MULT_LSB - 1:osc_pkg::STAT_VALID_BIT + 1] == 11'h0)
      else $error("Spare status bits are not zero.");

   // Unmapped addresses read as zero.
   unmapped_read_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      other_read_done_s |-> o_avs_readdata == 32'h0)
      else $error("Unmapped address returned nonzero data.");

   // Both routing outputs carry the same decision.
   // The clock tree takes one and the divider chain the other, so they must agree.
   pll_mirror_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      o_main_from_sub == o_pll_enable)
      else $error("PLL enable and sub clock routing disagree.");

   // Crystal and RC main types never route the sub clock.
   // A false route here would run the core from a 32 kHz-class source times a multiplier.
   no_pll_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      non_pll_cfg_s |=> !o_pll_enable && !o_main_from_sub)
      else $error("Sub clock routed although PLL mode is not selected.");

   // One check per ratio code 0 to 3 and one shared by codes 4 to 7, each against the package constant for its codes.
   // The multiplier lags the field by one edge, hence the next-cycle form.
   mult_x130_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      o_pll_ratio_sel == 3'h0 |=> o_pll_mult_q4 == osc_pkg::MULT_Q4_130)
      else $error("Ratio code 0 does not give multiplier 130.");

   mult_x65_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      o_pll_ratio_sel == 3'h1 |=> o_pll_mult_q4 == osc_pkg::MULT_Q4_65)
      else $error("Ratio code 1 does not give multiplier 65.");

   mult_half_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      o_pll_ratio_sel == 3'h2 |=> o_pll_mult_q4 == osc_pkg::MULT_Q4_65_2)
      else $error("Ratio code 2 does not give multiplier 65/2.");

   mult_quarter_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      o_pll_ratio_sel == 3'h3 |=> o_pll_mult_q4 == osc_pkg::MULT_Q4_65_4)
      else $error("Ratio code 3 does not give multiplier 65/4.");

   // Any code with the top bit set shares the largest multiplier.
   mult_x244_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      o_pll_ratio_sel[2] |=> o_pll_mult_q4 == osc_pkg::MULT_Q4_244)
      else $error("Ratio code with top bit set does not give multiplier 244.");

   // Once captured, the configuration stays valid until the next reset.
   // Dropping it would let a moved pin be captured a second time.
   valid_sticky_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      o_cfg_valid |=> o_cfg_valid)
      else $error("Configuration valid dropped outside reset.");

   // Capture lands on the first edge after release, never later.
   capture_edge_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      chk_run_q |-> o_cfg_valid)
      else $error("Options were not captured on the first edge after reset.");

   // Before that edge the configuration still shows its reset value.
   capture_wait_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      !chk_run_q |-> !o_cfg_valid)
      else $error("Options were captured before reset release.");

endmodule : osc_mode_and_pll_select

`default_nettype wire

// ==== test/test_osc_mode_and_pll_select.sv ====
// Self-checking bench for the oscillator mode and PLL ratio block.
// Assumes Avalon-MM requests end when waitrequest is sampled low, and options captured after reset.
`timescale 1ns/10ps
`default_nettype none
module test_osc_mode_and_pll_select;
   logic              clk_sys, reset, sel_hi, sel_lo, sel_sub, rd, wr, waitreq, valid, pll_en, from_sub;
   logic [3:0]        addr, be;
   logic [31:0]       wdata, rdata, got;
   logic [2:0]        ratio;
   logic [9:0]        mult_q4;
   logic [1:0]        main_exp;
   osc_pkg::osc_cfg_t cfg;
   int                fail_count, total_checks;
   // Multiplier in quarter units: 130, 65, 65/2, 65/4, then 244 for the top bit set.
   logic [9:0] mult_tbl [8] = '{10'h208, 10'h104, 10'h082, 10'h041, 10'h3d0, 10'h3d0, 10'h3d0, 10'h3d0};
   osc_mode_and_pll_select DUT (.i_clk_sys(clk_sys), .i_reset(reset), .i_main_osc_type_sel_hi(sel_hi),
      .i_main_osc_type_sel_lo(sel_lo), .i_sub_osc_type_sel(sel_sub), .i_avs_address(addr), .i_avs_read(rd),
      .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be), .o_avs_readdata(rdata),
      .o_avs_waitrequest(waitreq), .o_osc_cfg(cfg), .o_cfg_valid(valid), .o_pll_enable(pll_en),
      .o_main_from_sub(from_sub), .o_pll_ratio_sel(ratio), .o_pll_mult_q4(mult_q4));
   // Free-running 10 MHz clock.
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // One Avalon-MM transfer; the request is held until waitrequest is sampled low.
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
      @(posedge clk_sys);
      rd <= ~w;
      wr <= w;
      addr <= a;
      wdata <= d;
      be <= b;
      do begin
         @(posedge clk_sys);
      end while (waitreq !== 1'b0);
      got = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : bus
   task automatic restart(input logic [2:0] opt);
      @(posedge clk_sys);
      {sel_sub, sel_hi, sel_lo} <= opt;
      reset <= 1'b1;
      repeat (10) @(posedge clk_sys);
      reset <= 1'b0;
      repeat (3) @(posedge clk_sys);
   endtask : restart
   // Every option word, then the pins are flipped to prove the capture is static.
   task automatic test_modes();
      for (int k = 0; k < 8; k++) begin
         restart(3'(k));
         main_exp = (k[1:0] == 2'h0) ? 2'h0 : (k[1:0] == 2'h1) ? 2'h1 : 2'h2;
         check(32'(cfg.main_type), 32'(main_exp));
         check(32'(cfg.sub_crystal), 32'(k[2]));
         check(32'({pll_en, from_sub}), {30'h0, {2{main_exp == 2'h2}}});
         bus(1'b0, 4'h4, 32'h0, 4'hf);
         check(32'(got[4:0]), 32'({1'b1, main_exp == 2'h2, k[2], main_exp}));
         {sel_sub, sel_hi, sel_lo} <= ~3'(k);
         repeat (6) @(posedge clk_sys);
         check(32'(cfg), 32'({main_exp, k[2]}));
      end
   endtask : test_modes
   // Every ratio code, stray bits set, plus dropped writes and an unmapped read.
   task automatic test_ratio();
      restart(3'h2);
      bus(1'b0, 4'h0, 32'h0, 4'hf);
      check(got, 32'h0);
      check(32'(mult_q4), 32'h208);
      for (int k = 0; k < 8; k++) begin
         bus(1'b1, 4'h0, 32'hffff_ff8f | (k << 4), 4'hf);
         repeat (2) @(posedge clk_sys);
         check(32'(ratio), 32'(k));
         check(32'(mult_q4), 32'(mult_tbl[k]));
         bus(1'b0, 4'h0, 32'h0, 4'hf);
         check(got, 32'(k << 4));
         bus(1'b0, 4'h4, 32'h0, 4'hf);
         check(32'(got[25:16]), 32'(mult_tbl[k]));
      end
      bus(1'b1, 4'h0, 32'h10, 4'he);
      bus(1'b1, 4'h4, 32'h0, 4'hf);
      bus(1'b1, 4'h8, 32'h20, 4'hf);
      bus(1'b0, 4'h8, 32'h0, 4'hf);
      check(got, 32'h0);
      bus(1'b0, 4'h0, 32'h0, 4'hf);
      check(got, 32'h70);
   endtask : test_ratio
   task automatic results();
      $display("Checks %0d, mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : results
   // Watchdog: the whole run needs under a tenth of this span.
   initial begin
      #400000;
      fail_count++;
      results();
   end
   // Main sequence; all inputs get a value at time zero.
   initial begin
      {reset, sel_hi, sel_lo, sel_sub, rd, wr, addr, be, wdata} <= {1'b1, 45'h0};
      test_modes();
      test_ratio();
      results();
   end
endmodule : test_osc_mode_and_pll_select
`default_nettype wire
